// *** hdl/data_space_address_decoder.sv ***
// data space decoder, arbiter and flash access gate
//
// Overview of operation
// - I/O registers occupy bytes 0 to FFF
// - short I/O forms reach 0x00 to 0x3F
// - bit operations only at 0x00 to 0x1F
// - EEPROM at 1000, SRAM at 2000
// - EEPROM mapped, byte and page access
// - gap after EEPROM is reserved, empty
// - above SRAM goes external, up to FFFFFF, or up to 85FFF in two-port mode
// - linear spaces, no paging register
// - each flash location holds 16 bits
// - boot, application and table sections locked
// - flash write only from boot section
// - locked regions refuse write or read
// - separate target buses allow simultaneous access
// - fixed priority between core and DMA
// - core data accesses take one cycle
// - external port reach depends on mode
`timescale 1ns/100ps
module data_space_address_decoder
    import mem_map_pkg::*;
#(
    parameter logic [23:0] EE_LAST = 24'h0017FF,
    parameter logic [23:0] SRAM_LAST = 24'h005FFF
) (
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire bus_req_type cpu_req, // core data request
    input wire bus_req_type dma_req, // dma data request
    output bus_rsp_type cpu_rsp, // core answer
    output bus_rsp_type dma_rsp, // dma answer
    output tgt_req_type io_bus, // to I/O registers
    input wire logic [DATA_W-1:0] io_rdata, // I/O read data
    output tgt_req_type ee_bus, // to mapped EEPROM
    output logic ee_page, // EEPROM page access
    input wire logic [DATA_W-1:0] ee_rdata, // EEPROM read data
    output tgt_req_type sram_bus, // to internal SRAM
    input wire logic [DATA_W-1:0] sram_rdata, // SRAM read data
    output tgt_req_type ext_bus, // to external memory port
    input wire logic [DATA_W-1:0] ext_rdata, // external read data
    input wire logic [1:0] ext_mode, // external port configuration
    input wire logic [PADDR_W-1:0] fetch_pc, // executing word address
    input wire logic pm_req, // flash access request
    input wire logic pm_write, // flash access is a store
    input wire logic [PADDR_W-1:0] pm_addr, // flash word address
    input wire logic [15:0] pm_wdata, // flash word to write
    input wire lock_type locks, // lock bits
    output logic pm_go, // flash access granted
    output logic pm_we, // flash write strobe
    output logic [PADDR_W-1:0] pm_addr_out, // flash word address out
    output logic [15:0] pm_wdata_out, // flash word out
    output logic pm_refused // flash access refused
);
    // ****************************************
    // decode
    // ****************************************
    // each master gets its own copy of the comparators; addresses are flat byte indices
    function automatic target_type decode(input bus_req_type r, input logic [1:0] m);
        logic [23:0] ext_last;
        ext_last = (m == EXT_MODE_TWO) ? (SRAM_LAST + EXT_LAST_TWO_PORT + 24'h1) : DATA_LAST;
        if (m == EXT_MODE_TWO && SRAM_LAST + EXT_LAST_TWO_PORT < SRAM_LAST) begin
            ext_last = DATA_LAST;
        end
        if (!r.valid) begin
            return TGT_NONE;
        end
        unique case (r.kind)
            ACC_IO_IN, ACC_IO_OUT:
                return (r.addr <= IO_SHORT_LAST) ? TGT_IO : TGT_NONE;
            ACC_IO_BIT:
                return (r.addr <= IO_BIT_LAST) ? TGT_IO : TGT_NONE;
            default: begin
                if (r.addr <= IO_LAST) begin
                    return TGT_IO;
                end else if (r.addr >= EE_BASE && r.addr <= EE_LAST) begin
                    return TGT_EE;
                end else if (r.addr < SRAM_BASE) begin
                    return TGT_GAP;
                end else if (r.addr <= SRAM_LAST) begin
                    return TGT_SRAM;
                end else if (r.addr <= ext_last) begin
                    return TGT_EXT;
                end
                return TGT_NONE;
            end
        endcase
    endfunction

    target_type cpu_t;
    target_type dma_t;
    logic dma_go;
    logic dma_ee_bad;

    always_comb begin
        cpu_t = decode(cpu_req, ext_mode);
        dma_t = decode(dma_req, ext_mode);
        // dma may read but not write mapped EEPROM
        dma_ee_bad = (dma_t == TGT_EE) && dma_req.write;
        // core wins a shared target; dma waits one cycle at most per core access
        dma_go = (dma_t != TGT_NONE) && !dma_ee_bad && !(dma_t == cpu_t && dma_t != TGT_GAP);
    end

    // ****************************************
    // target buses
    // ****************************************
    function automatic tgt_req_type route(input target_type want, input target_type ct,
                                          input bus_req_type c, input logic dg,
                                          input target_type dt, input bus_req_type d);
        tgt_req_type o;
        o = '0;
        if (ct == want) begin
            o = '{valid: 1'b1, write: c.write, addr: c.addr, wdata: c.wdata};
        end else if (dg && dt == want) begin
            o = '{valid: 1'b1, write: d.write, addr: d.addr, wdata: d.wdata};
        end
        return o;
    endfunction

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            io_bus <= '0;
            ee_bus <= '0;
            sram_bus <= '0;
            ext_bus <= '0;
            ee_page <= 1'b0;
        end else begin
            io_bus <= route(TGT_IO, cpu_t, cpu_req, dma_go, dma_t, dma_req);
            ee_bus <= route(TGT_EE, cpu_t, cpu_req, dma_go, dma_t, dma_req);
            sram_bus <= route(TGT_SRAM, cpu_t, cpu_req, dma_go, dma_t, dma_req);
            ext_bus <= route(TGT_EXT, cpu_t, cpu_req, dma_go, dma_t, dma_req);
            ee_page <= (cpu_t == TGT_EE) && (cpu_req.kind == ACC_EE_PAGE);
        end
    end

    // ****************************************
    // answers
    // ****************************************
    target_type cpu_t_q;
    target_type dma_t_q;
    logic cpu_err_q;
    logic dma_err_q;
    logic dma_done_q;

    function automatic logic [DATA_W-1:0] pick(input target_type t, input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b,
                                               input logic [DATA_W-1:0] c,
                                               input logic [DATA_W-1:0] d);
        unique case (t)
            TGT_IO: return a;
            TGT_EE: return b;
            TGT_SRAM: return c;
            TGT_EXT: return d;
            default: return '0;
        endcase
    endfunction

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_t_q <= TGT_NONE;
            dma_t_q <= TGT_NONE;
            cpu_err_q <= 1'b0;
            dma_err_q <= 1'b0;
            dma_done_q <= 1'b0;
        end else begin
            cpu_t_q <= cpu_t;
            dma_t_q <= dma_go ? dma_t : TGT_NONE;
            cpu_err_q <= cpu_req.valid && cpu_t == TGT_NONE;
            dma_err_q <= dma_req.valid && (dma_t == TGT_NONE || dma_ee_bad);
            dma_done_q <= dma_go || (dma_req.valid && (dma_t == TGT_NONE || dma_ee_bad));
        end
    end

    // core always answers the cycle after its request
    always_comb begin
        cpu_rsp.done = (cpu_t_q != TGT_NONE) || cpu_err_q;
        cpu_rsp.error = cpu_err_q;
        cpu_rsp.rdata = pick(cpu_t_q, io_rdata, ee_rdata, sram_rdata, ext_rdata);
        dma_rsp.done = dma_done_q;
        dma_rsp.error = dma_err_q;
        dma_rsp.rdata = pick(dma_t_q, io_rdata, ee_rdata, sram_rdata, ext_rdata);
    end

    // ****************************************
    // program flash
    // ****************************************
    logic allow;

    flash_guard u_guard (
        .fetch_pc(fetch_pc),
        .pm_addr(pm_addr),
        .pm_write(pm_write),
        .locks(locks),
        .allow(allow),
        .pm_sec()
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pm_go <= 1'b0;
            pm_we <= 1'b0;
            pm_refused <= 1'b0;
            pm_addr_out <= '0;
            pm_wdata_out <= '0;
        end else begin
            pm_go <= pm_req && allow;
            pm_we <= pm_req && pm_write && allow;
            pm_refused <= pm_req && !allow;
            pm_addr_out <= pm_addr;
            pm_wdata_out <= pm_wdata;
        end
    end
endmodule // data_space_address_decoder

// *** hdl/flash_guard.sv ***
// flash section decoding and lock protection for program memory accesses
`timescale 1ns/100ps
module flash_guard
    import mem_map_pkg::*;
#(
    parameter logic [17:0] APP_TBL_BASE = 18'h1F000,
    parameter logic [17:0] BOOT_BASE = 18'h20000
) (
    input wire logic [PADDR_W-1:0] fetch_pc, // word address of executing instruction
    input wire logic [PADDR_W-1:0] pm_addr, // word address of flash access
    input wire logic pm_write, // access is store_program_word
    input wire lock_type locks, // programmed lock bits
    output logic allow, // access may proceed
    output section_type pm_sec // section of pm_addr
);
    function automatic section_type sec_of(input logic [PADDR_W-1:0] a);
        if (a >= BOOT_BASE) begin
            return SEC_BOOT;
        end else if (a >= APP_TBL_BASE) begin
            return SEC_APP_TABLE;
        end
        return SEC_APP;
    endfunction

    logic from_boot;
    logic locked;

    always_comb begin
        pm_sec = sec_of(pm_addr);
        from_boot = (sec_of(fetch_pc) == SEC_BOOT);
        unique case (pm_sec)
            SEC_APP: locked = pm_write ? (locks.app_wr | locks.app_rd) : locks.app_rd;
            SEC_APP_TABLE: locked = pm_write ? (locks.tbl_wr | locks.tbl_rd) : locks.tbl_rd;
            SEC_BOOT: locked = pm_write ? (locks.boot_wr | locks.boot_rd) : locks.boot_rd;
            default: locked = 1'b1;
        endcase
        allow = !locked && (!pm_write || from_boot);
    end
endmodule // flash_guard

// *** hdl/mem_map_pkg.sv ***
// constants and carrier types for the data space address decoder
package mem_map_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int PADDR_W = 18;

    // data space layout
    localparam logic [23:0] IO_LAST = 24'h000FFF;
    localparam logic [23:0] IO_SHORT_LAST = 24'h00003F;
    localparam logic [23:0] IO_BIT_LAST = 24'h00001F;
    localparam logic [23:0] EE_BASE = 24'h001000;
    localparam logic [23:0] SRAM_BASE = 24'h002000;
    localparam logic [23:0] DATA_LAST = 24'hFFFFFF;

    // external memory port reach
    localparam int EXT_PORTS = 3;
    localparam logic [23:0] EXT_LAST_TWO_PORT = 24'h07FFFF;
    localparam logic [23:0] EXT_LAST_SDRAM = 24'hFFFFFF;

    // target codes
    typedef enum logic [2:0] {
        TGT_IO,
        TGT_EE,
        TGT_GAP,
        TGT_SRAM,
        TGT_EXT,
        TGT_NONE
    } target_type;

    // access kinds the core can issue
    typedef enum logic [2:0] {
        ACC_LOAD,
        ACC_STORE,
        ACC_IO_IN,
        ACC_IO_OUT,
        ACC_IO_BIT,
        ACC_EE_PAGE
    } access_type;

    typedef struct packed {
        logic valid;
        logic write;
        access_type kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic done;
        logic error;
        logic [DATA_W-1:0] rdata;
    } bus_rsp_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tgt_req_type;

    // flash sections by word address
    typedef enum logic [1:0] {
        SEC_APP,
        SEC_APP_TABLE,
        SEC_BOOT
    } section_type;

    typedef struct packed {
        logic app_wr;
        logic app_rd;
        logic tbl_wr;
        logic tbl_rd;
        logic boot_wr;
        logic boot_rd;
    } lock_type;

    localparam logic [1:0] EXT_MODE_TWO = 2'h0;
    localparam logic [1:0] EXT_MODE_THREE = 2'h1;
    localparam logic [1:0] EXT_MODE_SDRAM = 2'h2;

endpackage

// *** verif/addr_decode_monitor.sv ***
// assertion checker for the data space address decoder
`timescale 1ns/100ps
module addr_decode_monitor
    import mem_map_pkg::*;
#(
    parameter logic [23:0] EE_LAST = 24'h0017FF,
    parameter logic [23:0] SRAM_LAST = 24'h005FFF,
    parameter logic [17:0] BOOT_BASE = 18'h20000
) (
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire bus_req_type cpu_req, // core request
    input wire bus_req_type dma_req, // dma request
    input wire bus_rsp_type cpu_rsp, // core answer
    input wire bus_rsp_type dma_rsp, // dma answer
    input wire tgt_req_type io_bus, // io target
    input wire tgt_req_type sram_bus, // sram target
    input wire tgt_req_type ext_bus, // external target
    input wire logic [1:0] ext_mode, // external mode
    input wire logic [PADDR_W-1:0] fetch_pc, // executing address
    input wire logic pm_req, // flash request
    input wire logic pm_write, // flash store
    input wire logic pm_we, // flash strobe
    input wire logic pm_refused // flash refusal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic ld, gap, c_sram, d_sram;
    assign ld = cpu_req.valid && cpu_req.kind == ACC_LOAD;
    assign gap = cpu_req.addr > EE_LAST && cpu_req.addr < SRAM_BASE;
    assign c_sram = cpu_req.addr >= SRAM_BASE && cpu_req.addr <= SRAM_LAST;
    assign d_sram = dma_req.addr >= SRAM_BASE && dma_req.addr <= SRAM_LAST;
    chk_cpu_one_cycle: assert property (cpu_req.valid |=> cpu_rsp.done)
        else $error("core access not answered next cycle");
    chk_gap_reads_zero: assert property (ld && gap |=> cpu_rsp.done && !cpu_rsp.error
        && cpu_rsp.rdata == 8'h00) else $error("gap read not zero");
    chk_short_io_range: assert property (cpu_req.valid && cpu_req.kind == ACC_IO_IN
        && cpu_req.addr > IO_SHORT_LAST |=> cpu_rsp.error) else $error("short io out of range");
    chk_bit_io_range: assert property (cpu_req.valid && cpu_req.kind == ACC_IO_BIT
        && cpu_req.addr > IO_BIT_LAST |=> cpu_rsp.error) else $error("bit io out of range");
    chk_sram_route: assert property (ld && c_sram |=> sram_bus.valid
        && sram_bus.addr == $past(cpu_req.addr)) else $error("sram not routed");
    chk_io_route: assert property (ld && cpu_req.addr <= IO_LAST |=> io_bus.valid)
        else $error("io not routed");
    chk_ext_route: assert property (ld && cpu_req.addr > SRAM_LAST
        && ext_mode == EXT_MODE_SDRAM |=> ext_bus.valid) else $error("external not routed");
    chk_core_wins: assert property (cpu_req.valid && dma_req.valid && c_sram && d_sram
        |=> cpu_rsp.done && !dma_rsp.done) else $error("dma won over core");
    chk_boot_only_write: assert property (pm_req && pm_write && fetch_pc < BOOT_BASE
        |=> pm_refused && !pm_we) else $error("flash write outside boot");
    cover property (ld && gap);
    cover property (cpu_req.valid && dma_req.valid);
    cover property (pm_req && pm_write && fetch_pc >= BOOT_BASE);
endmodule // addr_decode_monitor
bind data_space_address_decoder addr_decode_monitor #(.EE_LAST(EE_LAST), .SRAM_LAST(SRAM_LAST))
    mon_i (.sys_clk(sys_clk), .rst_b(rst_b), .cpu_req(cpu_req), .dma_req(dma_req),
    .cpu_rsp(cpu_rsp), .dma_rsp(dma_rsp), .io_bus(io_bus), .sram_bus(sram_bus),
    .ext_bus(ext_bus), .ext_mode(ext_mode), .fetch_pc(fetch_pc), .pm_req(pm_req),
    .pm_write(pm_write), .pm_we(pm_we), .pm_refused(pm_refused));

// *** verif/target_model.sv ***
// target memories answering the decoder's four target buses
`timescale 1ns/100ps
module target_model
    import mem_map_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire tgt_req_type io_bus, // io request
    input wire tgt_req_type ee_bus, // eeprom request
    input wire tgt_req_type sram_bus, // sram request
    input wire tgt_req_type ext_bus, // external request
    output logic [DATA_W-1:0] io_rdata, // io data
    output logic [DATA_W-1:0] ee_rdata, // eeprom data
    output logic [DATA_W-1:0] sram_rdata, // sram data
    output logic [DATA_W-1:0] ext_rdata // external data
);
    // data answers in the cycle the bus shows valid; idle targets show a
    // value that flips every cycle so a stale read is caught
    logic [DATA_W-1:0] idle_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_q <= 8'hC3;
        end else begin
            idle_q <= ~idle_q;
        end
    end

    always_comb begin
        io_rdata = io_bus.valid ? io_bus.addr[7:0] ^ 8'h5A : idle_q;
        ee_rdata = ee_bus.valid ? ee_bus.addr[7:0] ^ 8'h5A : idle_q;
        sram_rdata = sram_bus.valid ? sram_bus.addr[7:0] ^ 8'h5A : idle_q;
        ext_rdata = ext_bus.valid ? ext_bus.addr[7:0] ^ 8'h5A : idle_q;
    end
endmodule // target_model

// *** verif/tb_top.sv ***
// self-checking bench for the data space address decoder
`timescale 1ns/100ps
module tb_top;
    import mem_map_pkg::*;
    logic sys_clk = 0, rst_b = 0, pm_req = 0, pm_write = 0, ee_page, pm_go, pm_we, pm_refused;
    bus_req_type cpu_req = '0, dma_req = '0;
    bus_rsp_type cpu_rsp, dma_rsp;
    tgt_req_type io_bus, ee_bus, sram_bus, ext_bus;
    logic [7:0] io_rdata, ee_rdata, sram_rdata, ext_rdata;
    logic [1:0] ext_mode = EXT_MODE_SDRAM;
    logic [17:0] fetch_pc = '0, pm_addr = '0, pm_addr_out;
    logic [15:0] pm_wdata = '0, pm_wdata_out;
    logic [31:0] r;
    lock_type locks = '0;
    int err_total = 0, n_tests = 0, cyc = 0;
    logic [23:0] dir [10] = '{24'h000000, 24'h000FFF, 24'h001000, 24'h0017FF, 24'h001800,
        24'h001FFF, 24'h002000, 24'h005FFF, 24'h006000, 24'hFFFFFF};
    data_space_address_decoder data_space_address_decoder_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .cpu_req(cpu_req), .dma_req(dma_req), .cpu_rsp(cpu_rsp), .dma_rsp(dma_rsp),
        .io_bus(io_bus), .io_rdata(io_rdata), .ee_bus(ee_bus), .ee_page(ee_page),
        .ee_rdata(ee_rdata), .sram_bus(sram_bus), .sram_rdata(sram_rdata), .ext_bus(ext_bus),
        .ext_rdata(ext_rdata), .ext_mode(ext_mode), .fetch_pc(fetch_pc), .pm_req(pm_req),
        .pm_write(pm_write), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .locks(locks),
        .pm_go(pm_go), .pm_we(pm_we), .pm_addr_out(pm_addr_out), .pm_wdata_out(pm_wdata_out),
        .pm_refused(pm_refused));
    target_model target_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .io_bus(io_bus),
        .ee_bus(ee_bus), .sram_bus(sram_bus), .ext_bus(ext_bus), .io_rdata(io_rdata),
        .ee_rdata(ee_rdata), .sram_rdata(sram_rdata), .ext_rdata(ext_rdata));
    initial forever #5 sys_clk = ~sys_clk;
    // reference map: 0 io, 1 eeprom, 2 gap, 3 sram, 4 external
    function automatic int tgt(logic [23:0] a);
        if (a <= 24'h000FFF) return 0;
        if (a <= 24'h0017FF) return 1;
        if (a < 24'h002000) return 2;
        return (a <= 24'h005FFF) ? 3 : 4;
    endfunction
    function automatic logic bad(access_type k, logic [23:0] a);
        return (k inside {ACC_IO_IN, ACC_IO_OUT} && a > 24'h00003F) ||
            (k == ACC_IO_BIT && a > 24'h00001F);
    endfunction
    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d of %0d compares", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cpu_op(access_type k, logic w, logic [23:0] a);
        int t;
        t = tgt(a);
        @(negedge sys_clk);
        cpu_req <= '{1'b1, w, k, a, 8'h3C};
        @(negedge sys_clk);
        cpu_req.valid <= 1'b0;
        cmp(cpu_rsp.done, 1);
        cmp(cpu_rsp.error, bad(k, a));
        if (!bad(k, a)) begin
            cmp({ext_bus.valid, sram_bus.valid, 1'b0, ee_bus.valid, io_bus.valid},
                5'(1 << t) & 5'h1B);
            if (!w) cmp(cpu_rsp.rdata, t == 2 ? 0 : a[7:0] ^ 8'h5A);
        end
    endtask
    task automatic both(logic cv, logic [23:0] ca, logic [23:0] da, logic dw, logic [2:0] e);
        @(negedge sys_clk);
        cpu_req <= '{cv, 1'b0, ACC_LOAD, ca, 8'h00};
        dma_req <= '{1'b1, dw, dw ? ACC_STORE : ACC_LOAD, da, 8'hA7};
        @(negedge sys_clk);
        {cpu_req.valid, dma_req.valid} <= 2'b00;
        cmp({cpu_rsp.done, dma_rsp.done, dma_rsp.error}, e);
        if (e == 3'b110) cmp(dma_rsp.rdata, da[7:0] ^ 8'h5A);
        if (cv) cmp(cpu_rsp.rdata, ca[7:0] ^ 8'h5A);
    endtask
    task automatic flash(logic [17:0] pc, logic [5:0] lk, logic [1:0] e);
        @(negedge sys_clk);
        {pm_req, pm_write, fetch_pc, locks, pm_addr} <= {2'b11, pc, lk, 18'h00100};
        pm_wdata <= 16'hA55A;
        @(negedge sys_clk);
        pm_req <= 1'b0;
        cmp({pm_we, pm_refused}, e);
        cmp(pm_go, e[1]);
        cmp(pm_addr_out, 18'h00100);
        cmp(pm_wdata_out, 16'hA55A);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h8CEF));
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b <= 1'b1;
        foreach (dir[i]) cpu_op(ACC_LOAD, 1'b0, dir[i]);
        cpu_op(ACC_STORE, 1'b1, 24'h001900);
        cpu_op(ACC_IO_IN, 1'b0, 24'h00003F);
        cpu_op(ACC_IO_OUT, 1'b1, 24'h000040);
        cpu_op(ACC_IO_BIT, 1'b1, 24'h00001F);
        cpu_op(ACC_IO_BIT, 1'b1, 24'h000020);
        cpu_op(ACC_EE_PAGE, 1'b0, 24'h001000);
        cmp(ee_page, 1);
        repeat (40) begin
            r = $urandom;
            cpu_op(r[0] ? ACC_STORE : ACC_LOAD, r[0], r[31:8]);
        end
        both(1'b1, 24'h002010, 24'h002020, 1'b0, 3'b100);
        both(1'b1, 24'h002010, 24'h000010, 1'b0, 3'b110);
        both(1'b0, 24'h002010, 24'h001000, 1'b1, 3'b011);
        flash(18'h00000, 6'h00, 2'b01);
        flash(18'h20000, 6'h00, 2'b10);
        flash(18'h20000, 6'h20, 2'b01);
        ext_mode <= EXT_MODE_TWO;
        cpu_op(ACC_LOAD, 1'b0, 24'h085FFF);
        test_done();
    end
endmodule // tb_top
